/* File: design/sir_top.sv */
// serial channel interrupt and transfer request logic with axi4-lite access
//
// Functional notes
// - four request sources per channel
// - each source maskable by control enables
// - each request kind on own line
// - empty flag raises transmit empty request
// - end flag raises transmit end request
// - transmit empty request triggers transfer controllers
// - transfer done clears empty flag automatically
// - transmit end never triggers transfer controllers
// - full flag raises receive full request
// - any error flag raises receive error
// - receive full request triggers transfer controllers
// - transfer done clears full flag automatically
// - receive error never triggers transfer controllers
// - channels two to four lack dma path
// - no full set during frame/parity error
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module sir_top
   import sir_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RESETN,
   input  wire logic [2:0]  CHAN_ID,
   input  wire logic        TX_BUF_EMPTY_SET,
   input  wire logic        TX_END_SET,
   input  wire logic        RX_FULL_SET,
   input  wire logic        OVERRUN_SET,
   input  wire logic        PARITY_SET,
   input  wire logic        FRAMING_SET,
   input  wire logic        TX_DMA_DONE,
   input  wire logic        TX_XFC_DONE,
   input  wire logic        RX_DMA_DONE,
   input  wire logic        RX_XFC_DONE,
   output logic             TRANSMIT_END_IRQ,
   output logic             RECEIVE_ERROR_IRQ,
   output logic             RECEIVE_FULL_IRQ,
   output logic             TRANSMIT_EMPTY_IRQ,
   output logic             TX_DMA_REQ,
   output logic             TX_XFC_REQ,
   output logic             RX_DMA_REQ,
   output logic             RX_XFC_REQ,
   output logic             TX_ENABLE,
   output logic             RX_ENABLE,
   input  wire logic [31:0] AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [31:0] ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY
);
   typedef struct packed {
      logic [7:0]     ctrl;
      logic [7:0]     stat;
      logic           chan_dma_ok;
      logic           aw_got;
      logic [3:0]     aw_addr;
      logic           w_got;
      logic [7:0]     w_data;
      logic           w_strb0;
      sir_bus_state_t wr_st;
      logic [1:0]     bresp;
      sir_bus_state_t rd_st;
      logic [31:0]    rdata;
      logic [1:0]     rresp;
   } sir_state_t;

   sir_state_t q;
   sir_state_t d;

   logic rx_err;
   logic rx_blocked;
   logic tx_xfer_done;
   logic rx_xfer_done;
   logic do_write;
   logic do_read;
   logic [7:0] stat_set;
   logic [7:0] stat_wclr;
   logic [3:0] ar_off;
   logic       tx_xfer;
   logic       rx_xfer;
   logic       te_dummy;
   logic       er_dummy;

   assign rx_err = q.stat[STAT_OVR_BIT] | q.stat[STAT_PER_BIT]
                 | q.stat[STAT_FRAME_BIT];
   // framing or parity error freezes the channel until cleared
   assign rx_blocked = q.stat[STAT_FRAME_BIT] | q.stat[STAT_PER_BIT];
   assign tx_xfer_done = TX_DMA_DONE | TX_XFC_DONE;
   assign rx_xfer_done = RX_DMA_DONE | RX_XFC_DONE;
   assign do_write = (q.wr_st == SIR_IDLE) && q.aw_got && q.w_got;
   assign do_read  = (q.rd_st == SIR_IDLE) && ARVALID;
   assign ar_off   = ARADDR[3:0];

   // four request lines, each its own gate
   sir_req_gate #(.XFER_OK(1'b1)) u_empty (
      .flag        (q.stat[STAT_EMPTY_BIT]),
      .enable      (q.ctrl[CTRL_EMPTY_EN_BIT]),
      .chan_dma_ok (1'b1),
      .irq         (TRANSMIT_EMPTY_IRQ),
      .xfer_req    (tx_xfer)
   );
   sir_req_gate #(.XFER_OK(1'b0)) u_end (
      .flag        (q.stat[STAT_END_BIT]),
      .enable      (q.ctrl[CTRL_END_EN_BIT]),
      .chan_dma_ok (1'b1),
      .irq         (TRANSMIT_END_IRQ),
      .xfer_req    (te_dummy)
   );
   sir_req_gate #(.XFER_OK(1'b1)) u_full (
      .flag        (q.stat[STAT_FULL_BIT]),
      .enable      (q.ctrl[CTRL_RECV_EN_BIT]),
      .chan_dma_ok (1'b1),
      .irq         (RECEIVE_FULL_IRQ),
      .xfer_req    (rx_xfer)
   );
   sir_req_gate #(.XFER_OK(1'b0)) u_err (
      .flag        (rx_err),
      .enable      (q.ctrl[CTRL_RECV_EN_BIT]),
      .chan_dma_ok (1'b1),
      .irq         (RECEIVE_ERROR_IRQ),
      .xfer_req    (er_dummy)
   );

   // dma path only on the low channels; the other controller serves all
   assign TX_DMA_REQ = tx_xfer & q.chan_dma_ok & ~te_dummy;
   assign RX_DMA_REQ = rx_xfer & q.chan_dma_ok & ~er_dummy;
   assign TX_XFC_REQ = tx_xfer;
   assign RX_XFC_REQ = rx_xfer;
   assign TX_ENABLE  = q.ctrl[CTRL_TE_BIT] & ~rx_blocked;
   assign RX_ENABLE  = q.ctrl[CTRL_RE_BIT] & ~rx_blocked;

   assign AWREADY = (q.wr_st == SIR_IDLE) && !q.aw_got;
   assign WREADY  = (q.wr_st == SIR_IDLE) && !q.w_got;
   assign BVALID  = (q.wr_st == SIR_RESP);
   assign BRESP   = q.bresp;
   assign ARREADY = (q.rd_st == SIR_IDLE);
   assign RVALID  = (q.rd_st == SIR_RESP);
   assign RDATA   = q.rdata;
   assign RRESP   = q.rresp;

   always_comb begin
      d = q;
      d.chan_dma_ok = (CHAN_ID <= DMA_LAST_CHAN);
      stat_set  = 8'h00;
      stat_wclr = 8'h00;
      if (AWVALID && AWREADY) begin
         d.aw_got  = 1'b1;
         d.aw_addr = AWADDR[3:0];
      end
      if (WVALID && WREADY) begin
         d.w_got   = 1'b1;
         d.w_data  = WDATA[7:0];
         d.w_strb0 = WSTRB[0];
      end
      unique case (q.wr_st)
         SIR_IDLE: begin
            if (do_write) begin
               d.aw_got = 1'b0;
               d.w_got  = 1'b0;
               d.wr_st  = SIR_RESP;
               d.bresp  = RESP_OKAY;
               if (q.aw_addr == CTRL_OFF) begin
                  if (q.w_strb0) begin
                     d.ctrl = q.w_data;
                  end
               end else if (q.aw_addr == STAT_OFF) begin
                  // write zero clears a flag; writing one keeps it
                  if (q.w_strb0) begin
                     stat_wclr = ~q.w_data & STAT_CLR_MASK;
                  end
               end else if (q.aw_addr == EVENT_OFF) begin
                  if (q.w_strb0) begin
                     stat_set = q.w_data & STAT_CLR_MASK;
                  end
               end else begin
                  d.bresp = RESP_SLVERR;
               end
            end
         end
         SIR_RESP: begin
            if (BREADY) begin
               d.wr_st = SIR_IDLE;
            end
         end
      endcase
      unique case (q.rd_st)
         SIR_IDLE: begin
            if (do_read) begin
               d.rd_st = SIR_RESP;
               d.rresp = RESP_OKAY;
               if (ar_off == CTRL_OFF) begin
                  d.rdata = {24'h000000, q.ctrl};
               end else if (ar_off == STAT_OFF) begin
                  d.rdata = {24'h000000, q.stat};
               end else if (ar_off == EVENT_OFF) begin
                  d.rdata = 32'h00000000;
               end else begin
                  d.rdata = 32'h00000000;
                  d.rresp = RESP_SLVERR;
               end
            end
         end
         SIR_RESP: begin
            if (RREADY) begin
               d.rd_st = SIR_IDLE;
            end
         end
      endcase
      // hardware events; set wins over any clear in the same cycle
      stat_set[STAT_EMPTY_BIT] = stat_set[STAT_EMPTY_BIT] | TX_BUF_EMPTY_SET;
      stat_set[STAT_END_BIT]   = stat_set[STAT_END_BIT] | TX_END_SET;
      stat_set[STAT_FULL_BIT]  = (stat_set[STAT_FULL_BIT] | RX_FULL_SET)
                               & ~rx_blocked;
      stat_set[STAT_OVR_BIT]   = stat_set[STAT_OVR_BIT] | OVERRUN_SET;
      stat_set[STAT_PER_BIT]   = stat_set[STAT_PER_BIT] | PARITY_SET;
      stat_set[STAT_FRAME_BIT] = stat_set[STAT_FRAME_BIT] | FRAMING_SET;
      if (tx_xfer_done) begin
         stat_wclr[STAT_EMPTY_BIT] = 1'b1;
      end
      if (rx_xfer_done) begin
         stat_wclr[STAT_FULL_BIT] = 1'b1;
      end
      d.stat = (q.stat & ~stat_wclr) | stat_set;
   end

   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         q             <= '0;
         q.ctrl        <= CTRL_RESET;
         q.stat        <= STAT_RESET;
         q.wr_st       <= SIR_IDLE;
         q.rd_st       <= SIR_IDLE;
         q.bresp       <= RESP_OKAY;
         q.rresp       <= RESP_OKAY;
      end else begin
         q <= d;
      end
   end

   // all checks live in the one clock domain of the block
   default clocking chk_clk @(posedge CLOCK);
   endclocking
   default disable iff (!RESETN);

   // a transfer clear only counts when no set lands in the same cycle,
   // since the set wins and the flag must then stay up
   sequence seq_tx_clear;
      tx_xfer_done && !stat_set[STAT_EMPTY_BIT];
   endsequence
   sequence seq_rx_clear;
      rx_xfer_done && !stat_set[STAT_FULL_BIT];
   endsequence
   // the channel strap is registered, so it must stand for two cycles
   sequence seq_high_chan;
      (CHAN_ID > DMA_LAST_CHAN) ##1 (CHAN_ID > DMA_LAST_CHAN);
   endsequence
   sequence seq_b_wait;
      BVALID && !BREADY;
   endsequence
   sequence seq_r_wait;
      RVALID && !RREADY;
   endsequence

   chk_empty_gate: assert property (
      TRANSMIT_EMPTY_IRQ ==
      (q.stat[STAT_EMPTY_BIT] & q.ctrl[CTRL_EMPTY_EN_BIT]))
      else $error("transmit empty request wrong");

   chk_end_gate: assert property (
      TRANSMIT_END_IRQ ==
      (q.stat[STAT_END_BIT] & q.ctrl[CTRL_END_EN_BIT]))
      else $error("transmit end request wrong");

   chk_full_gate: assert property (
      RECEIVE_FULL_IRQ ==
      (q.stat[STAT_FULL_BIT] & q.ctrl[CTRL_RECV_EN_BIT]))
      else $error("receive full request wrong");

   chk_err_gate: assert property (
      RECEIVE_ERROR_IRQ == (rx_err & q.ctrl[CTRL_RECV_EN_BIT]))
      else $error("receive error request wrong");

   chk_tx_autoclr: assert property (
      seq_tx_clear |=> !q.stat[STAT_EMPTY_BIT])
      else $error("empty flag not cleared by transfer");

   chk_rx_autoclr: assert property (
      seq_rx_clear |=> !q.stat[STAT_FULL_BIT])
      else $error("full flag not cleared by transfer");

   chk_set_wins: assert property (
      TX_BUF_EMPTY_SET |=> q.stat[STAT_EMPTY_BIT])
      else $error("empty flag set lost");

   chk_dma_chan: assert property (
      seq_high_chan |-> !TX_DMA_REQ && !RX_DMA_REQ)
      else $error("dma request from high channel");

   chk_full_block: assert property (
      rx_blocked && !q.stat[STAT_FULL_BIT] |=> !q.stat[STAT_FULL_BIT])
      else $error("full flag set during error");

   chk_run_block: assert property (
      rx_blocked |-> !TX_ENABLE && !RX_ENABLE)
      else $error("transfer enabled during error");

   chk_empty_noreq: assert property (
      !q.stat[STAT_EMPTY_BIT] |-> !TX_XFC_REQ && !TX_DMA_REQ)
      else $error("transfer request without empty flag");

   chk_tx_xfer: assert property (
      TRANSMIT_EMPTY_IRQ |-> TX_XFC_REQ)
      else $error("empty request not offered for transfer");

   chk_rx_xfer: assert property (
      RECEIVE_FULL_IRQ |-> RX_XFC_REQ)
      else $error("full request not offered for transfer");

   chk_end_noxfer: assert property (
      TRANSMIT_END_IRQ && !q.stat[STAT_EMPTY_BIT]
      |-> !TX_XFC_REQ && !TX_DMA_REQ)
      else $error("transmit end started a transfer");

   chk_err_noxfer: assert property (
      RECEIVE_ERROR_IRQ && !q.stat[STAT_FULL_BIT]
      |-> !RX_XFC_REQ && !RX_DMA_REQ)
      else $error("receive error started a transfer");

   chk_write_resp: assert property (
      do_write |=> BVALID)
      else $error("write response missing");

   chk_bresp_hold: assert property (
      seq_b_wait |=> BVALID && $stable(BRESP))
      else $error("write response dropped");

   chk_read_resp: assert property (
      do_read |=> RVALID)
      else $error("read response missing");

   chk_rdata_hold: assert property (
      seq_r_wait |=> RVALID && $stable(RDATA))
      else $error("read data dropped");
endmodule

/* File: design/sir_pkg.sv */
// package for the serial channel request logic: register map, fields, resets
package sir_pkg;
   // register byte offsets
   localparam logic [3:0] CTRL_OFF       = 4'h0;
   localparam logic [3:0] STAT_OFF       = 4'h4;
   localparam logic [3:0] EVENT_OFF      = 4'h8;
   // control register fields
   localparam int         CTRL_END_EN_BIT   = 2;
   localparam int         CTRL_RECV_EN_BIT  = 6;
   localparam int         CTRL_EMPTY_EN_BIT = 7;
   localparam int         CTRL_TE_BIT    = 5;
   localparam int         CTRL_RE_BIT    = 4;
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   // status register fields
   localparam int         STAT_END_BIT   = 2;
   localparam int         STAT_PER_BIT   = 3;
   localparam int         STAT_FRAME_BIT = 4;
   localparam int         STAT_OVR_BIT   = 5;
   localparam int         STAT_FULL_BIT  = 6;
   localparam int         STAT_EMPTY_BIT = 7;
   localparam logic [7:0] STAT_RESET     = 8'h84;
   localparam logic [7:0] STAT_CLR_MASK  = 8'hFC;
   // channel number strap, index of last channel with dma path
   localparam logic [2:0] DMA_LAST_CHAN  = 3'h1;
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;
   typedef enum logic [1:0] {
      SIR_IDLE,
      SIR_RESP
   } sir_bus_state_t;
endpackage

/* File: design/sir_req_gate.sv */
// one request line: flag anded with its enable, with optional transfer path
`timescale 1ns/1ps
module sir_req_gate
   import sir_pkg::*;
#(
   parameter bit XFER_OK = 1'b0
) (
   input  wire logic flag,
   input  wire logic enable,
   input  wire logic chan_dma_ok,
   output logic      irq,
   output logic      xfer_req
);
   assign irq      = flag & enable;
   // error and end kinds pass XFER_OK=0, so never reach a transfer controller
   assign xfer_req = XFER_OK ? (flag & enable & chan_dma_ok) : 1'b0;
endmodule

/* File: test/sir_xfer_partner.sv */
// transfer controller model: serves both kinds of requests after a lag
`timescale 1ns/1ps
module sir_xfer_partner #(
   parameter int LAG = 3
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       serve,
   input  wire logic [3:0] req,
   output logic      [3:0] done
);
   int cnt [4];
   initial done = 4'h0;
   // count parks one past the lag: the request is still high on the
   // clearing edge and must not be served twice
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         done[i] <= rst_n && serve && req[i] && cnt[i] == LAG;
         if (!rst_n || !serve || !req[i])
            cnt[i] <= 0;
         else if (cnt[i] <= LAG)
            cnt[i] <= cnt[i] + 1;
      end
   end
endmodule

/* File: test/sir_top_tb_top.sv */
// testbench for the serial channel request logic
`timescale 1ns/1ps
module sir_top_tb_top
   import sir_pkg::*;
;
   logic        CLOCK, RESETN, serve;
   logic [2:0]  CHAN_ID;
   logic [5:0]  set_v;
   logic [3:0]  xfer_done;
   logic        TRANSMIT_END_IRQ, RECEIVE_ERROR_IRQ;
   logic        RECEIVE_FULL_IRQ, TRANSMIT_EMPTY_IRQ, TX_ENABLE, RX_ENABLE;
   logic        TX_DMA_REQ, TX_XFC_REQ, RX_DMA_REQ, RX_XFC_REQ;
   logic [31:0] AWADDR, WDATA, ARADDR, RDATA;
   logic [3:0]  WSTRB;
   logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
   logic        ARVALID, ARREADY, RVALID, RREADY;
   logic [1:0]  BRESP, RRESP;
   logic [9:0]  outs;
   int          failures = 0, tests_run = 0, cycles = 0;
   assign outs = {RX_ENABLE, TX_ENABLE, RX_XFC_REQ, RX_DMA_REQ, TX_XFC_REQ,
                  TX_DMA_REQ, TRANSMIT_END_IRQ, RECEIVE_ERROR_IRQ,
                  RECEIVE_FULL_IRQ, TRANSMIT_EMPTY_IRQ};
   sir_top sir_top_inst (
      .CLOCK, .RESETN, .CHAN_ID,
      .TX_BUF_EMPTY_SET(set_v[0]), .TX_END_SET(set_v[1]),
      .RX_FULL_SET(set_v[2]), .OVERRUN_SET(set_v[3]),
      .PARITY_SET(set_v[4]), .FRAMING_SET(set_v[5]),
      .TX_DMA_DONE(xfer_done[0]), .TX_XFC_DONE(xfer_done[1]),
      .RX_DMA_DONE(xfer_done[2]), .RX_XFC_DONE(xfer_done[3]),
      .TRANSMIT_END_IRQ, .RECEIVE_ERROR_IRQ, .RECEIVE_FULL_IRQ,
      .TRANSMIT_EMPTY_IRQ, .TX_DMA_REQ, .TX_XFC_REQ, .RX_DMA_REQ,
      .RX_XFC_REQ, .TX_ENABLE, .RX_ENABLE, .AWADDR, .AWVALID, .AWREADY,
      .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
      .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY
   );
   // the model takes dma when offered, the other controller otherwise
   sir_xfer_partner sir_xfer_partner_inst (
      .clk(CLOCK), .rst_n(RESETN), .serve,
      .req({RX_XFC_REQ & ~RX_DMA_REQ, RX_DMA_REQ,
            TX_XFC_REQ & ~TX_DMA_REQ, TX_DMA_REQ}),
      .done(xfer_done)
   );
   initial begin
      CLOCK = 1'b0;
      forever #25 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         failures++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // ready and valid only move on rising edges, so the falling edge
   // sees what the next rising edge samples
   task automatic wr(input logic [3:0] off, input logic [31:0] d,
                     input logic [1:0] exp);
      logic a, w, b;
      logic [1:0] resp;
      a = 1'b1;
      w = 1'b1;
      AWADDR <= {28'h0, off};
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do begin
         @(negedge CLOCK);
         a = a & ~AWREADY;
         w = w & ~WREADY;
         b = BVALID;
         resp = BRESP;
         @(posedge CLOCK);
         AWVALID <= a;
         WVALID <= w;
      end while (!b);
      BREADY <= 1'b0;
      // let an edge pass so the next call never re-drives in this step
      @(posedge CLOCK);
      check(resp, exp);
   endtask
   task automatic rd(input logic [3:0] off, input logic [31:0] exp,
                     input logic [1:0] exp_resp);
      logic a, r;
      logic [31:0] d;
      logic [1:0] resp;
      a = 1'b1;
      ARADDR <= {28'h0, off};
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do begin
         @(negedge CLOCK);
         a = a & ~ARREADY;
         r = RVALID;
         d = RDATA;
         resp = RRESP;
         @(posedge CLOCK);
         ARVALID <= a;
      end while (!r);
      RREADY <= 1'b0;
      @(posedge CLOCK);
      check(d, exp);
      check(resp, exp_resp);
   endtask
   task automatic pulse(input int idx);
      set_v[idx] <= 1'b1;
      @(posedge CLOCK);
      set_v[idx] <= 1'b0;
      @(posedge CLOCK);
   endtask
   task automatic look(input logic [9:0] mask, input logic [9:0] exp);
      @(negedge CLOCK);
      check(outs & mask, exp);
      @(posedge CLOCK);
   endtask
   task automatic t_reset();
      rd(CTRL_OFF, {24'h0, CTRL_RESET}, RESP_OKAY);
      rd(STAT_OFF, {24'h0, STAT_RESET}, RESP_OKAY);
      look(10'h00F, 10'h000);
      rd(4'hC, 32'h0, RESP_SLVERR);
      wr(4'hC, 32'hFF, RESP_SLVERR);
      $display("reset test finished");
   endtask
   task automatic t_mask();
      logic [7:0] en [5] = '{8'h80, 8'h40, 8'h04, 8'hC4, 8'h00};
      logic [3:0] ex [5] = '{4'h1, 4'h6, 4'h8, 4'hF, 4'h0};
      wr(EVENT_OFF, 32'h60, RESP_OKAY);
      rd(STAT_OFF, 32'hE4, RESP_OKAY);
      for (int i = 0; i < 5; i++) begin
         wr(CTRL_OFF, {24'h0, en[i]}, RESP_OKAY);
         look(10'h00F, {6'h0, ex[i]});
      end
      $display("mask test finished");
   endtask
   task automatic t_err();
      wr(STAT_OFF, 32'h0, RESP_OKAY);
      wr(CTRL_OFF, 32'h40, RESP_OKAY);
      for (int i = 3; i < 6; i++) begin
         pulse(i);
         look(10'h0C6, 10'h004);
         wr(STAT_OFF, 32'h0, RESP_OKAY);
      end
      $display("error test finished");
   endtask
   task automatic t_frame();
      wr(CTRL_OFF, 32'h70, RESP_OKAY);
      look(10'h300, 10'h300);
      pulse(5);
      pulse(2);
      look(10'h302, 10'h000);
      rd(STAT_OFF, 32'h10, RESP_OKAY);
      wr(STAT_OFF, 32'h0, RESP_OKAY);
      look(10'h300, 10'h300);
      $display("frame error test finished");
   endtask
   task automatic t_chan();
      wr(CTRL_OFF, 32'hC4, RESP_OKAY);
      pulse(0);
      pulse(2);
      for (int c = 0; c < 5; c++) begin
         CHAN_ID <= 3'(c);
         repeat (2) @(posedge CLOCK);
         look(10'h0F0, c <= 1 ? 10'h0F0 : 10'h0A0);
      end
      wr(STAT_OFF, 32'h0, RESP_OKAY);
      pulse(1);
      pulse(3);
      look(10'h0FF, 10'h00C);
      $display("channel test finished");
   endtask
   task automatic t_auto();
      int n;
      wr(STAT_OFF, 32'h0, RESP_OKAY);
      serve <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         CHAN_ID <= k[0] ? 3'h2 : 3'h0;
         repeat (2) @(posedge CLOCK);
         pulse(k[1] ? 2 : 0);
         n = 0;
         do begin
            @(negedge CLOCK);
            n++;
         end while (outs[1:0] != 2'b00 && n < 20);
         @(posedge CLOCK);
         rd(STAT_OFF, 32'h0, RESP_OKAY);
      end
      serve <= 1'b0;
      $display("auto clear test finished");
   endtask
   initial begin
      RESETN = 1'b0;
      serve = 1'b0;
      CHAN_ID = 3'h0;
      set_v = 6'h00;
      {AWADDR, WDATA, ARADDR} = '0;
      WSTRB = 4'hF;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
      repeat (5) @(posedge CLOCK);
      RESETN <= 1'b1;
      @(posedge CLOCK);
      t_reset();
      t_mask();
      t_err();
      t_frame();
      t_chan();
      t_auto();
      complete_run();
   end
endmodule
